// *** hdl/ssm_consts.svh ***
// Constants of the supply status monitor: sizes, offsets, fields, timing.
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH
`define SSM_NCH 4
`define SSM_NBRD 2
`define SSM_NFAN 3
`define SSM_NRAIL 4
`define SSM_NAME_LEN 11
`define SSM_CLK_MHZ 100
`define SSM_TICK_MS 1000
`define SSM_TICK_CYC (`SSM_TICK_MS * 1000 * `SSM_CLK_MHZ)
`define SSM_TRIP_CC 10'd1000
`define SSM_FAN_DIV 19'd5
// Pin vector layout: limit flags, rails, then the front-panel levels.
`define SSM_PIN_RAIL `SSM_NCH
`define SSM_PIN_VOLTAGE_SETPOINT_SELECT (`SSM_NCH + `SSM_NRAIL)
`define SSM_PIN_CURRENT_LIMIT_SELECT (`SSM_PIN_VOLTAGE_SETPOINT_SELECT + 1)
`define SSM_PIN_EN (`SSM_PIN_VOLTAGE_SETPOINT_SELECT + 2)
`define SSM_PIN_CHK (`SSM_PIN_VOLTAGE_SETPOINT_SELECT + 3)
`define SSM_PW (`SSM_PIN_VOLTAGE_SETPOINT_SELECT + 4)
// Global registers (byte addresses).
`define SSM_A_CTRL 12'h000
`define SSM_A_STAT 12'h004
`define SSM_A_ALRM 12'h008
`define SSM_A_FAN 12'h00c
`define SSM_A_TEMP 12'h010
`define SSM_A_NAME 12'h014
// Channel blocks: base + channel * 0x20, word index inside a block.
`define SSM_A_CHBASE 12'h040
`define SSM_A_CHEND 12'h0c0
`define SSM_O_VA 3'd0
`define SSM_O_VB 3'd1
`define SSM_O_IA 3'd2
`define SSM_O_IB 3'd3
`define SSM_O_TRIP 3'd4
`define SSM_O_RATE 3'd5
`define SSM_O_CEIL 3'd6
`define SSM_O_CTRL 3'd7
// Reset values.
`define SSM_RST_RMASK 3'h1
`define SSM_RST_TRIP 10'h3e8
`define SSM_RST_CEIL 16'hffff
`endif

// *** hdl/ssm_pkg.sv ***
// Types shared by the supply status monitor.
package ssm_pkg;
   // One channel's programmed values and live state.
   typedef struct packed {
      logic [15:0] va;
      logic [15:0] vb;
      logic [15:0] ia;
      logic [15:0] ib;
      logic [15:0] ceil;
      logic [15:0] rise;
      logic [15:0] fall;
      logic [15:0] vout;
      logic [9:0] trip;
      logic [9:0] cnt;
      logic power;
      logic style;
      logic tripped;
   } ssm_chan_s;
   // Crate-wide status levels; the indicators mirror them.
   typedef struct packed {
      logic overcurrentAny;
      logic undervoltageAny;
      logic overvoltageAny;
      logic timeoutShutdownFlag;
      logic restartIndicator;
      logic selftestOk;
      logic combinedAlarmOut;
      logic anyOutputActive;
      logic overTemp;
      logic fanFail;
      logic powerFail;
   } ssm_flags_s;
   // Shutdown style after a trip.
   typedef enum logic {SSM_RAMP = 1'b0, SSM_KILL = 1'b1} ssm_style_e;
endpackage : ssm_pkg

// *** hdl/supply_status_monitor.sv ***
// Crate status monitor: channel trip, ramp, setpoint select and status flags.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`include "ssm_consts.svh"
module supply_status_monitor #(
   parameter int TICK_CYCLES = `SSM_TICK_CYC
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`SSM_NCH-1:0] atLimitPin,
   input wire logic [`SSM_NRAIL-1:0] railOkPin,
   input wire logic voltageSetpointSelect,
   input wire logic currentLimitSelect,
   input wire logic outputsEnabledPin,
   input wire logic checkDonePin,
   input wire logic [`SSM_NCH-1:0][15:0] vmon,
   input wire logic [`SSM_NBRD-1:0][7:0] boardTemp,
   input wire logic [`SSM_NFAN-1:0][15:0] fanSpeed,
   input wire logic cpuResetEvt,
   input wire logic boardResetEvt,
   input wire logic [7:0] clusterNum,
   input wire logic [7:0] slotNum,
   output logic [`SSM_NCH-1:0][15:0] voltageDrive,
   output logic [`SSM_NCH-1:0][15:0] currentLimit,
   output ssm_pkg::ssm_flags_s status,
   output ssm_pkg::ssm_flags_s leds
);
   ////////////////////////////////////////////////////////////////////////
   // All state of the block in one record.
   typedef struct packed {
      ssm_pkg::ssm_chan_s [`SSM_NCH-1:0] chan;
      logic [`SSM_PW-1:0] s1;
      logic [`SSM_PW-1:0] s2;
      logic [`SSM_PW-1:0] s3;
      logic [`SSM_PW-1:0] pin;
      logic [`SSM_NCH-1:0][`SSM_NAME_LEN-1:0][7:0] names;
      logic [5:0] nameSel;
      logic nameErr;
      logic [2:0] restartMask;
      logic porPending;
      logic [3:0] alarmMask;
      logic alarmAnd;
      logic [15:0] fanNom;
      logic [7:0] tMin;
      logic [7:0] tMax;
      logic [26:0] tickCnt;
      logic [31:0] rdata;
      logic [`SSM_NCH-1:0][15:0] iLim;
      ssm_pkg::ssm_flags_s flags;
   } ssm_state_s;

   ssm_state_s st; // Registered state.
   ssm_state_s next_st; // Next state.

   ////////////////////////////////////////////////////////////////////////
   // Accepts digits, letters and the symbols # & % $ * _ -.
   function automatic logic nameCharOk(input logic [7:0] c);
      nameCharOk = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a) ||
         (c >= 8'h61 && c <= 8'h7a) || c == 8'h23 || c == 8'h26 ||
         c == 8'h25 || c == 8'h24 || c == 8'h2a || c == 8'h5f || c == 8'h2d;
   endfunction : nameCharOk

   // Clamps a programmed voltage to the channel's ceiling.
   function automatic logic [15:0] clampV(input logic [15:0] v, input logic [15:0] lim);
      clampV = (v > lim) ? lim : v;
   endfunction : clampV

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: every access completes in its first access cycle.
   wire logic chHit = paddr >= `SSM_A_CHBASE && paddr < `SSM_A_CHEND;
   wire logic glHit = paddr <= `SSM_A_NAME;
   assign pready = psel & penable;
   // An unmapped or unaligned address is refused; both cases answer with an error.
   assign pslverr = psel & penable & (~(chHit | glHit) | (paddr[1:0] != 2'b00));
   assign prdata = st.rdata;
   assign status = st.flags;
   assign leds = st.flags;
   assign currentLimit = st.iLim;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for bus, pins, channels and flags.
   always_comb
   begin
      logic wr;
      logic setup;
      logic tick;
      logic clr;
      logic on;
      logic [1:0] ch;
      logic [2:0] off;
      logic [15:0] tgt;
      logic [15:0] v;
      logic [3:0] cond;
      logic [5:0] ni;
      wr = 1'b0;
      setup = 1'b0;
      tick = 1'b0;
      clr = 1'b0;
      on = 1'b0;
      ch = 2'd0;
      off = 3'd0;
      tgt = 16'h0000;
      v = 16'h0000;
      cond = 4'h0;
      ni = 6'd0;
      next_st = st;
      // Three-stage pin sampler; a change counts once stages two and three agree.
      next_st.s1 = {checkDonePin, outputsEnabledPin, currentLimitSelect,
         voltageSetpointSelect, railOkPin, atLimitPin};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int b = 0; b < `SSM_PW; b++)
      begin
         if (st.s2[b] == st.s3[b])
         begin
            next_st.pin[b] = st.s3[b];
         end
      end
      // One-second tick divider; the ramp and trip timer advance on it.
      tick = st.tickCnt == 27'(TICK_CYCLES - 1);
      next_st.tickCnt = tick ? 27'd0 : st.tickCnt + 27'd1;
      // Bus decode; writes take effect at the access edge.
      wr = psel & penable & pwrite & ~pslverr;
      setup = psel & ~penable & ~pwrite;
      // Channel blocks start at 0x40, so block two of the 32-byte grid is channel 0.
      ch = paddr[6:5] ^ 2'b10;
      off = paddr[4:2];
      clr = wr && paddr == `SSM_A_CTRL && pwdata[0];
      if (wr && glHit)
      begin
         case (paddr)
            `SSM_A_CTRL: next_st.restartMask = pwdata[3:1];
            `SSM_A_ALRM:
            begin
               next_st.alarmMask = pwdata[3:0];
               next_st.alarmAnd = pwdata[4];
            end
            `SSM_A_FAN: next_st.fanNom = pwdata[15:0];
            `SSM_A_TEMP:
            begin
               next_st.tMin = pwdata[7:0];
               next_st.tMax = pwdata[15:8];
            end
            `SSM_A_NAME:
            begin
               ni = pwdata[13:8];
               next_st.nameSel = ni;
               if (!pwdata[15])
               begin
                  if (nameCharOk(pwdata[7:0]) && ni[3:0] < 4'(`SSM_NAME_LEN))
                  begin
                     next_st.names[ni[5:4]][ni[3:0]] = pwdata[7:0];
                  end
                  else
                  begin
                     next_st.nameErr = 1'b1;
                  end
               end
            end
            default: next_st.nameErr = next_st.nameErr;
         endcase
      end
      // Clear alarm drops the name error unless a new one arrives now.
      if (clr && !(wr && paddr == `SSM_A_NAME))
      begin
         next_st.nameErr = 1'b0;
      end
      // Per-channel programming, trip timer and output ramp.
      for (int c = 0; c < `SSM_NCH; c++)
      begin
         if (wr && chHit && ch == 2'(c))
         begin
            case (off)
               `SSM_O_VA: next_st.chan[c].va = clampV(pwdata[15:0], st.chan[c].ceil);
               `SSM_O_VB: next_st.chan[c].vb = clampV(pwdata[15:0], st.chan[c].ceil);
               `SSM_O_IA: next_st.chan[c].ia = pwdata[15:0];
               `SSM_O_IB: next_st.chan[c].ib = pwdata[15:0];
               `SSM_O_TRIP: next_st.chan[c].trip = pwdata[9:0];
               `SSM_O_RATE:
               begin
                  next_st.chan[c].rise = pwdata[15:0];
                  next_st.chan[c].fall = pwdata[31:16];
               end
               `SSM_O_CEIL:
               begin
                  next_st.chan[c].ceil = pwdata[15:0];
                  next_st.chan[c].va = clampV(st.chan[c].va, pwdata[15:0]);
                  next_st.chan[c].vb = clampV(st.chan[c].vb, pwdata[15:0]);
               end
               default:
               begin
                  next_st.chan[c].power = pwdata[0];
                  next_st.chan[c].style = pwdata[1];
               end
            endcase
         end
         // reload on trip write, clear, power on or overcurrent end
         if ((wr && chHit && ch == 2'(c) && (off == `SSM_O_TRIP ||
            (off == `SSM_O_CTRL && pwdata[0]))) || clr || !st.pin[c])
         begin
            next_st.chan[c].cnt = next_st.chan[c].trip;
            // power on or clear alarm ends the trip
            if (clr || (wr && chHit && ch == 2'(c) && off == `SSM_O_CTRL && pwdata[0]))
            begin
               next_st.chan[c].tripped = 1'b0;
            end
         end
         // trip value 1000 never counts down
         else if (tick && st.chan[c].trip < `SSM_TRIP_CC && !st.chan[c].tripped)
         begin
            if (st.chan[c].cnt <= 10'd1)
            begin
               next_st.chan[c].cnt = 10'd0;
               next_st.chan[c].tripped = 1'b1;
            end
            else
            begin
               next_st.chan[c].cnt = st.chan[c].cnt - 10'd1;
            end
         end
         on = st.chan[c].power & st.pin[`SSM_PIN_EN] & ~st.chan[c].tripped;
         tgt = on ? (st.pin[`SSM_PIN_VOLTAGE_SETPOINT_SELECT] ? st.chan[c].vb : st.chan[c].va) : 16'h0000;
         v = st.chan[c].vout;
         // kill drops the output at once after a trip
         if (st.chan[c].tripped && st.chan[c].style == ssm_pkg::SSM_KILL)
         begin
            next_st.chan[c].vout = 16'h0000;
         end
         // rise limited to rise rate per tick
         else if (tick && tgt > v)
         begin
            next_st.chan[c].vout = (tgt - v > st.chan[c].rise) ? v + st.chan[c].rise : tgt;
         end
         else if (tick && tgt < v)
         begin
            next_st.chan[c].vout = (v - tgt > st.chan[c].fall) ? v - st.chan[c].fall : tgt;
         end
         next_st.iLim[c] = st.pin[`SSM_PIN_CURRENT_LIMIT_SELECT] ? st.chan[c].ib : st.chan[c].ia;
      end
      // Status levels; comparisons only on settled, live channels to avoid
      // false alarms while a ramp is still under way.
      next_st.flags.undervoltageAny = 1'b0;
      next_st.flags.overvoltageAny = 1'b0;
      next_st.flags.anyOutputActive = 1'b0;
      next_st.flags.timeoutShutdownFlag = 1'b0;
      for (int c = 0; c < `SSM_NCH; c++)
      begin
         on = st.chan[c].power & st.pin[`SSM_PIN_EN] & ~st.chan[c].tripped;
         tgt = st.pin[`SSM_PIN_VOLTAGE_SETPOINT_SELECT] ? st.chan[c].vb : st.chan[c].va;
         if (on && st.chan[c].vout == tgt && vmon[c] < tgt)
         begin
            next_st.flags.undervoltageAny = 1'b1;
         end
         if (on && st.chan[c].vout == tgt && vmon[c] > tgt)
         begin
            next_st.flags.overvoltageAny = 1'b1;
         end
         if (st.chan[c].power && st.pin[`SSM_PIN_EN])
         begin
            next_st.flags.anyOutputActive = 1'b1;
         end
         if (st.chan[c].tripped)
         begin
            next_st.flags.timeoutShutdownFlag = 1'b1;
         end
      end
      next_st.flags.overcurrentAny = |st.pin[`SSM_NCH-1:0];
      next_st.flags.overTemp = 1'b0;
      for (int b = 0; b < `SSM_NBRD; b++)
      begin
         if (boardTemp[b] < st.tMin || boardTemp[b] > st.tMax)
         begin
            next_st.flags.overTemp = 1'b1;
         end
      end
      // fan below one fifth of nominal, a stopped fan included
      next_st.flags.fanFail = 1'b0;
      for (int f = 0; f < `SSM_NFAN; f++)
      begin
         if ({3'b000, fanSpeed[f]} * `SSM_FAN_DIV < {3'b000, st.fanNom})
         begin
            next_st.flags.fanFail = 1'b1;
         end
      end
      next_st.flags.powerFail = ~&st.pin[`SSM_PIN_VOLTAGE_SETPOINT_SELECT-1:`SSM_PIN_RAIL];
      // drops while fan or rail fails
      next_st.flags.selftestOk = st.pin[`SSM_PIN_CHK] & ~next_st.flags.fanFail &
         ~next_st.flags.powerFail;
      // restart by selected reset type; a new reset beats a clear
      next_st.porPending = 1'b0;
      if (clr)
      begin
         next_st.flags.restartIndicator = 1'b0;
      end
      if ((st.porPending && st.restartMask[0]) || (cpuResetEvt && st.restartMask[1]) ||
         (boardResetEvt && st.restartMask[2]))
      begin
         next_st.flags.restartIndicator = 1'b1;
      end
      // alarm combination, OR or AND of the selected conditions
      cond = {st.flags.timeoutShutdownFlag, st.flags.overvoltageAny,
         st.flags.undervoltageAny, st.flags.overcurrentAny};
      next_st.flags.combinedAlarmOut = st.alarmAnd ?
         (st.alarmMask != 4'h0 && (cond & st.alarmMask) == st.alarmMask) :
         |(cond & st.alarmMask);
      // Read data is captured in the setup cycle and shown in the access cycle.
      if (setup)
      begin
         next_st.rdata = 32'h00000000;
         // Unaligned channel addresses fall through to the zero default below.
         if (chHit && paddr[1:0] == 2'b00)
         begin
            case (off)
               `SSM_O_VA: next_st.rdata[15:0] = st.chan[ch].va;
               `SSM_O_VB: next_st.rdata[15:0] = st.chan[ch].vb;
               `SSM_O_IA: next_st.rdata[15:0] = st.chan[ch].ia;
               `SSM_O_IB: next_st.rdata[15:0] = st.chan[ch].ib;
               `SSM_O_TRIP: next_st.rdata = {12'h000, st.chan[ch].cnt, st.chan[ch].trip};
               `SSM_O_RATE: next_st.rdata = {st.chan[ch].fall, st.chan[ch].rise};
               `SSM_O_CEIL: next_st.rdata = {st.chan[ch].vout, st.chan[ch].ceil};
               default: next_st.rdata = {clusterNum, slotNum, 6'h00, ch, 5'h00,
                  st.chan[ch].tripped, st.chan[ch].style, st.chan[ch].power};
            endcase
         end
         else
         begin
            case (paddr)
               `SSM_A_CTRL: next_st.rdata[3:1] = st.restartMask;
               `SSM_A_STAT: next_st.rdata[10:0] = st.flags;
               `SSM_A_ALRM: next_st.rdata[4:0] = {st.alarmAnd, st.alarmMask};
               `SSM_A_FAN: next_st.rdata[15:0] = st.fanNom;
               `SSM_A_TEMP: next_st.rdata[15:0] = {st.tMax, st.tMin};
               `SSM_A_NAME: next_st.rdata[16:0] = {st.nameErr,
                  2'b00, st.nameSel, st.names[st.nameSel[5:4]][st.nameSel[3:0]]};
               default: next_st.rdata = 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; reset loads constants only.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.restartMask <= `SSM_RST_RMASK;
         st.porPending <= 1'b1;
         for (int c = 0; c < `SSM_NCH; c++)
         begin
            st.chan[c].trip <= `SSM_RST_TRIP;
            st.chan[c].cnt <= `SSM_RST_TRIP;
            st.chan[c].ceil <= `SSM_RST_CEIL;
         end
      end
      else
      begin
         st <= next_st;
      end
   end

   // Drive words come straight from the ramp registers.
   always_comb
   begin
      for (int c = 0; c < `SSM_NCH; c++)
      begin
         voltageDrive[c] = st.chan[c].vout;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks on the registered behaviour.
   a_oc_follow: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      1 |=> status.overcurrentAny == $past(|st.pin[`SSM_NCH-1:0]))
      else $error("overcurrent flag does not follow limit pins");
   a_cc_notrip: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(st.chan[0].tripped) |-> $past(st.chan[0].trip) < `SSM_TRIP_CC)
      else $error("channel tripped in constant current mode");
   a_kill_zero: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(st.chan[0].tripped) && st.chan[0].style |=> voltageDrive[0] == 16'h0000)
      else $error("kill shutdown did not zero the output");
   a_trip_flag: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      st.chan[0].tripped |=> status.timeoutShutdownFlag)
      else $error("trip flag missing after a trip");
   a_clear_reload: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      psel && penable && pwrite && paddr == `SSM_A_CTRL && pwdata[0]
      |=> !st.chan[0].tripped && st.chan[0].cnt == st.chan[0].trip)
      else $error("clear alarm did not end trip and reload counter");
   a_selftest_drop: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      status.fanFail || status.powerFail |-> !status.selftestOk)
      else $error("selftest ok while a fan or rail fails");
   a_rise_rate: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      voltageDrive[0] > $past(voltageDrive[0])
      |-> voltageDrive[0] - $past(voltageDrive[0]) <= $past(st.chan[0].rise))
      else $error("output rose faster than rise rate");
   a_current_limit_select_pick: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      1 |=> currentLimit[0] == ($past(st.pin[`SSM_PIN_CURRENT_LIMIT_SELECT]) ?
      $past(st.chan[0].ib) : $past(st.chan[0].ia)))
      else $error("current limit does not follow select");
endmodule : supply_status_monitor

// *** tb/ssm_boards.sv ***
// Behavioural model of the channel boards that feed the monitor.
`timescale 1ns/10ps
`include "ssm_consts.svh"
module ssm_boards (
   input wire logic ref_clk,
   input wire logic [`SSM_NCH-1:0][15:0] voltageDrive,
   input wire logic [`SSM_NCH-1:0] overLoad,
   input wire logic [15:0] vDelta,
   output logic [`SSM_NCH-1:0] atLimitPin,
   output logic [`SSM_NCH-1:0][15:0] vmon
);
   // Boards start quiet, with no channel at its limit.
   initial
   begin
      atLimitPin = '0;
      vmon = '0;
   end
   // A loaded channel only sits at its limit while it drives a voltage.
   // Readback is the drive plus an error offset, one clock late like a real ADC.
   always @(posedge ref_clk)
   begin
      for (int c = 0; c < `SSM_NCH; c++)
      begin
         atLimitPin[c] <= overLoad[c] && (voltageDrive[c] != 16'h0000);
         vmon[c] <= voltageDrive[c] + vDelta;
      end
   end
endmodule : ssm_boards

// *** tb/supply_status_monitor_test.sv ***
// Self-checking bench for the supply status monitor.
`timescale 1ns/10ps
`include "ssm_consts.svh"
module supply_status_monitor_test;
   // A short tick keeps trip and ramp runs brief.
   localparam int TICK = 10;
   // One expected read: value, compared bits and error response.
   typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} ssm_note_s;
   ssm_note_s notes[$];
   logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, cpuResetEvt = 1'b0, boardResetEvt = 1'b0, checkDonePin = 1'b0;
   logic voltageSetpointSelect = 1'b0, currentLimitSelect = 1'b0, outputsEnabledPin = 1'b0;
   logic [`SSM_NCH-1:0] atLimitPin, overLoad = 4'h0;
   logic [`SSM_NRAIL-1:0] railOkPin = 4'hf;
   logic [`SSM_NCH-1:0][15:0] vmon, voltageDrive, currentLimit;
   logic [`SSM_NBRD-1:0][7:0] boardTemp = {8'h1e, 8'h1e};
   logic [`SSM_NFAN-1:0][15:0] fanSpeed = {3{16'h00c8}};
   logic [7:0] clusterNum = 8'h00, slotNum = 8'h00;
   logic [15:0] vDelta = 16'h0000, va, vb, ia, ib;
   ssm_pkg::ssm_flags_s status, leds;
   int nFail = 0, samplesChecked = 0;
   // Temperature probes around the 5..65 window, and offsets for the readback.
   logic [7:0] tVals [4] = '{8'h04, 8'h05, 8'h41, 8'h42};
   logic [15:0] dVals [3] = '{16'h0001, 16'hffff, 16'h0000};
   logic [31:0] sExp [3] = '{32'h110, 32'h200, 32'h0};
   always #5 ref_clk = ~ref_clk;
   supply_status_monitor #(.TICK_CYCLES(TICK)) dut_u (.ref_clk, .rst_n, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .atLimitPin, .railOkPin,
      .voltageSetpointSelect, .currentLimitSelect, .outputsEnabledPin, .checkDonePin, .vmon,
      .boardTemp, .fanSpeed, .cpuResetEvt, .boardResetEvt, .clusterNum, .slotNum,
      .voltageDrive, .currentLimit, .status, .leds);
   ssm_boards board_u (.ref_clk, .voltageDrive, .overLoad, .vDelta, .atLimitPin, .vmon);
   ////////////////////////////////////////////////////////////////////////////////////
   // Counts every comparison and reports a mismatch at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samplesChecked++;
      if (seen !== exp)
      begin
         nFail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   // APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   // A read leaves its expectation for the watcher below.
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic err);
      notes.push_back('{e, m, err});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic st(input logic [31:0] e, input logic [31:0] m);
      rd(12'h004, e, m, 1'b0);
   endtask : st
   task automatic giveVerdict();
      if (nFail == 0 && samplesChecked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : giveVerdict
   // Watcher: the oldest note meets each completed read; a mismatch is tagged prdata or pslverr.
   always @(posedge ref_clk)
   begin
      if (psel && penable && pready && !pwrite && notes.size() > 0)
      begin
         chk(prdata & notes[0].mask, notes[0].exp, "prdata");
         chk({31'h0, pslverr}, {31'h0, notes[0].err}, "pslverr");
         void'(notes.pop_front());
      end
   end
   // Watchdog: far beyond the few hundred cycles the sequence needs.
   initial
   begin
      cyc(10000);
      nFail++;
      giveVerdict();
   end
   ////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(38));
      clusterNum <= 8'($urandom);
      slotNum <= 8'($urandom);
      va = 16'h0400 + 16'($urandom % 256);
      vb = va + 16'h0100;
      ia = 16'($urandom);
      ib = ~ia;
      cyc(3);
      rst_n <= 1'b1;
      cyc(8);
      rd(12'h004, 32'h40, 32'h40, 1'b0);
      rd(12'h050, 32'h000fa3e8, 32'h000fffff, 1'b0);
      rd(12'h0c0, 32'h0, 32'hffffffff, 1'b1);
      rd(12'h042, 32'h0, 32'hffffffff, 1'b1);
      rd(12'h07c, {clusterNum, slotNum, 16'h0100}, 32'hffff0300, 1'b0);
      // Supplies, fans at the 20 percent edge, then board temperatures.
      checkDonePin <= 1'b1;
      wr(12'h00c, 32'd1000);
      wr(12'h010, 32'h4105);
      cyc(8);
      st(32'h20, 32'h27);
      railOkPin <= ~(4'h1 << ($urandom % 4));
      cyc(8);
      st(32'h01, 32'h21);
      railOkPin <= 4'hf;
      fanSpeed[$urandom % 3] <= 16'd199;
      cyc(8);
      st(32'h02, 32'h23);
      fanSpeed <= {3{16'd200}};
      cyc(8);
      st(32'h20, 32'h23);
      foreach (tVals[i])
      begin
         boardTemp[1] <= tVals[i];
         cyc(8);
         st({29'h0, (i == 0 || i == 3), 2'h0}, 32'h4);
      end
      // Restart flag with only the processor reset selected.
      wr(12'h000, 32'h5);
      boardResetEvt <= 1'b1;
      cyc(1);
      boardResetEvt <= 1'b0;
      cyc(4);
      st(32'h0, 32'h40);
      cpuResetEvt <= 1'b1;
      cyc(1);
      cpuResetEvt <= 1'b0;
      cyc(4);
      st(32'h40, 32'h40);
      // Channel 0 ramps up slowly, then follows the selects.
      wr(12'h040, {16'h0, va});
      wr(12'h044, {16'h0, vb});
      wr(12'h048, {16'h0, ia});
      wr(12'h04c, {16'h0, ib});
      wr(12'h054, 32'hffff0100);
      outputsEnabledPin <= 1'b1;
      wr(12'h05c, 32'h3);
      cyc(2 * TICK + 5);
      chk({31'h0, voltageDrive[0] <= 16'h0300}, 32'h1, "ramp");
      cyc(12 * TICK);
      chk({16'h0, voltageDrive[0]}, {16'h0, va}, "drive a");
      chk({16'h0, currentLimit[0]}, {16'h0, ia}, "limit a");
      st(32'h08, 32'h08);
      voltageSetpointSelect <= 1'b1;
      currentLimitSelect <= 1'b1;
      cyc(4 * TICK);
      chk({16'h0, voltageDrive[0]}, {16'h0, vb}, "drive b");
      chk({16'h0, currentLimit[0]}, {16'h0, ib}, "limit b");
      // Combined alarm follows overvoltage alone.
      wr(12'h008, 32'h4);
      foreach (dVals[i])
      begin
         vDelta <= dVals[i];
         cyc(8);
         st(sExp[i], 32'h310);
      end
      // Overcurrent: endless at 1000, then a short trip with kill and a clear.
      overLoad <= 4'h1;
      cyc(20 * TICK);
      st(32'h400, 32'h480);
      wr(12'h050, 32'd3);
      st(32'h0, 32'h80);
      cyc(5 * TICK);
      st(32'h80, 32'h80);
      chk({16'h0, voltageDrive[0]}, 32'h0, "drive off");
      overLoad <= 4'h0;
      wr(12'h000, 32'h1);
      cyc(2);
      st(32'h0, 32'h80);
      chk({21'h0, leds}, {21'h0, status}, "leds");
      giveVerdict();
   end
endmodule : supply_status_monitor_test
